// *** exec_pkg.sv ***
package exec_pkg;

    // widths of the core datapath
    localparam int PC_W        = 13;
    localparam int INSTR_W     = 14;
    localparam int DATA_W      = 8;
    localparam int FILE_AW     = 7;
    localparam int FILE_DEPTH  = 128;
    localparam int STACK_DEPTH = 8;
    localparam int STACK_PW    = 3;
    localparam int BUS_AW      = 4;
    localparam int CALL_K_W    = 11;
    localparam int DEST_BIT    = 7;

    // opcode patterns, compared under a mask; the watchdog word is matched whole
    localparam logic [INSTR_W-1:0] WDOG_OPC   = 14'h0064;
    localparam logic [INSTR_W-1:0] CALL_MASK  = 14'h3800;
    localparam logic [INSTR_W-1:0] CALL_OPC   = 14'h2000;
    localparam logic [INSTR_W-1:0] FD_MASK    = 14'h3F00;
    localparam logic [INSTR_W-1:0] COMPLEMENT_FILE_OP_OPC   = 14'h0900;
    localparam logic [INSTR_W-1:0] DECREMENT_FILE_OP_OPC   = 14'h0300;
    localparam logic [INSTR_W-1:0] DSKIP_OPC  = 14'h0B00;
    localparam logic [INSTR_W-1:0] CLR_MASK   = 14'h3F80;
    localparam logic [INSTR_W-1:0] CLEAR_FILE_OP_OPC   = 14'h0180;
    localparam logic [INSTR_W-1:0] CLEAR_ACCUMULATOR_OP_OPC   = 14'h0100;

    // register offsets on the plain register port
    localparam logic [BUS_AW-1:0] REG_ACC      = 4'h0;
    localparam logic [BUS_AW-1:0] REG_STATUS   = 4'h1;
    localparam logic [BUS_AW-1:0] REG_PCLATCH  = 4'h2;
    localparam logic [BUS_AW-1:0] REG_PC_LO    = 4'h3;
    localparam logic [BUS_AW-1:0] REG_PC_HI    = 4'h4;
    localparam logic [BUS_AW-1:0] REG_STK_LO   = 4'h5;
    localparam logic [BUS_AW-1:0] REG_STK_HI   = 4'h6;
    localparam logic [BUS_AW-1:0] REG_FILE_IDX = 4'h7;
    localparam logic [BUS_AW-1:0] REG_FILE_DAT = 4'h8;

    // status field positions
    localparam int ST_C   = 0;
    localparam int ST_DC  = 1;
    localparam int ST_Z   = 2;
    localparam int ST_PD  = 3;
    localparam int ST_TO  = 4;

    // reset values
    localparam logic [DATA_W-1:0] ACC_RST     = 8'h00;
    localparam logic [DATA_W-1:0] PCLATCH_RST = 8'h00;
    localparam logic [PC_W-1:0]   PC_RST      = 13'h0000;
    localparam logic              TO_N_RST    = 1'b1;
    localparam logic              PD_N_RST    = 1'b1;

    typedef enum logic [2:0] {
        OP_NONE  = 3'b000,
        OP_WDOG  = 3'b001,
        OP_CALL  = 3'b010,
        OP_COMPLEMENT_FILE_OP  = 3'b011,
        OP_CLEAR_FILE_OP  = 3'b100,
        OP_DECREMENT_FILE_OP  = 3'b101,
        OP_CLEAR_ACCUMULATOR_OP  = 3'b110,
        OP_DSKIP = 3'b111
    } op_t;

    typedef enum logic [1:0] {
        PH_RUN   = 2'b00,
        PH_CALL2 = 2'b01,
        PH_SKIP2 = 2'b10
    } phase_t;

    typedef struct packed {
        phase_t                             phase;
        logic [PC_W-1:0]                    pc;
        logic [DATA_W-1:0]                  acc;
        logic                               c;
        logic                               dc;
        logic                               z;
        logic                               toN;
        logic                               pdN;
        logic [DATA_W-1:0]                  pcLatch;
        logic [FILE_AW-1:0]                 fileIdx;
        logic [FILE_DEPTH-1:0][DATA_W-1:0]  file;
        logic [DATA_W-1:0]                  rdData;
        logic                               wdogClr;
        logic                               ready;
    } exec_state_t;

    typedef struct packed {
        logic [STACK_PW-1:0]                  ptr;
        logic [STACK_DEPTH-1:0][PC_W-1:0]     slot;
    } stack_state_t;

    // instruction decode, used by the executor and its checks
    function automatic op_t decodeOp(input logic [INSTR_W-1:0] iw);
        op_t o;
        o = OP_NONE;
        if (iw == WDOG_OPC) begin
            o = OP_WDOG;
        end else if ((iw & CALL_MASK) == CALL_OPC) begin
            o = OP_CALL;
        end else if ((iw & FD_MASK) == COMPLEMENT_FILE_OP_OPC) begin
            o = OP_COMPLEMENT_FILE_OP;
        end else if ((iw & FD_MASK) == DECREMENT_FILE_OP_OPC) begin
            o = OP_DECREMENT_FILE_OP;
        end else if ((iw & FD_MASK) == DSKIP_OPC) begin
            o = OP_DSKIP;
        end else if ((iw & CLR_MASK) == CLEAR_FILE_OP_OPC) begin
            o = OP_CLEAR_FILE_OP;
        end else if ((iw & CLR_MASK) == CLEAR_ACCUMULATOR_OP_OPC) begin
            o = OP_CLEAR_ACCUMULATOR_OP;
        end
        return o;
    endfunction

endpackage

// *** stack_if.sv ***
`timescale 1ns/1ps
interface stack_if;
    import exec_pkg::*;
    logic            push;
    logic [PC_W-1:0] pushAddr;
    logic [PC_W-1:0] topAddr;

    modport pusher (output push, output pushAddr, input topAddr);
    modport keeper (input push, input pushAddr, output topAddr);
endinterface

// *** return_stack.sv ***
`timescale 1ns/1ps
module return_stack (
    input  wire logic   sys_clk,
    input  wire logic   rst,
    stack_if.keeper     stk
);
    import exec_pkg::*;

    stack_state_t s;
    stack_state_t n;

    // circular stack: a ninth push silently overwrites the oldest entry
    always_comb begin
        n = s;
        if (stk.push) begin
            n.slot[s.ptr] = stk.pushAddr;
            n.ptr         = s.ptr + 3'h1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

    // top is the most recently pushed slot
    assign stk.topAddr = s.slot[s.ptr - 3'h1];

    stack_top_a: assert property (@(posedge sys_clk) disable iff (rst)
        stk.push |=> stk.topAddr == $past(stk.pushAddr))  // RULE3
        else $error("stack top does not hold the pushed address");
endmodule

// *** cpu_instr_exec.sv ***
// Function
// RULE1: watchdog-clear op zeroes the watchdog counter and its prescaler; the core has neither and only pulses watchdogClear for one cycle.
// RULE2: watchdog-clear op sets timeout and power-down flags to one.
// RULE3: call pushes program counter plus one onto the return stack.
// RULE4: call loads eleven-bit target; upper two bits from latch bits 4..3.
// RULE5: call takes two instruction cycles.
// RULE6: complement inverts file register; destination bit picks accumulator or file.
// RULE7: clear-file writes zero to the file register and sets zero flag.
// RULE8: decrement subtracts one; destination bit picks accumulator or file.
// RULE9: clear-accumulator loads zero and sets zero flag.
// RULE10: decrement-skip subtracts one; destination bit picks accumulator or file.
// RULE11: zero result discards next instruction, making two cycles; else continue.
// RULE12: complement and decrement set zero flag from result; carries unchanged.
// RULE13: call and decrement-skip keep flags; watchdog-clear touches only its flags.
//
// The plain strobed port and the placing of the registers were decided locally.
`timescale 1ns/1ps
module cpu_instr_exec (
    input  wire logic                          sys_clk,
    input  wire logic                          rst,
    input  wire logic [exec_pkg::BUS_AW-1:0]   busAddr,
    input  wire logic [exec_pkg::DATA_W-1:0]   busWrData,
    input  wire logic                          busWr,
    input  wire logic                          busRd,
    output logic      [exec_pkg::DATA_W-1:0]   busRdData,
    input  wire logic [exec_pkg::INSTR_W-1:0]  instrWord,
    input  wire logic                          instrValid,
    output logic                               instrReady,
    output logic      [exec_pkg::PC_W-1:0]     progCounter,
    output logic                               watchdogClear,
    output logic                               timeoutFlagN,
    output logic                               powerdownFlagN,
    output logic                               zeroFlag,
    output logic      [exec_pkg::DATA_W-1:0]   accumulator
);
    import exec_pkg::*;

    exec_state_t s;
    exec_state_t n;

    stack_if stk ();

    logic                accept;
    op_t                 op;
    logic [FILE_AW-1:0]  fAddr;
    logic                toFile;
    logic [DATA_W-1:0]   fileRd;
    logic [DATA_W-1:0]   result;

    // operand fetch and arithmetic shared by execution and checks
    always_comb begin
        accept = (s.phase == PH_RUN) && instrValid;
        op     = decodeOp(instrWord);
        fAddr  = instrWord[FILE_AW-1:0];
        toFile = instrWord[DEST_BIT];
        fileRd = s.file[fAddr];
        result = (op == OP_COMPLEMENT_FILE_OP) ? ~fileRd : fileRd - 8'h01;
    end

    // next-state: register port first, then the executing instruction,
    // so a hardware update in the same cycle wins over a software write
    always_comb begin
        n          = s;
        n.wdogClr  = 1'b0;
        n.rdData   = '0;
        stk.push     = 1'b0;
        stk.pushAddr = s.pc + 13'h0001;

        // register writes
        if (busWr) begin
            case (busAddr)
                REG_ACC: begin
                    n.acc = busWrData;
                end
                REG_STATUS: begin
                    n.c   = busWrData[ST_C];
                    n.dc  = busWrData[ST_DC];
                    n.z   = busWrData[ST_Z];
                    n.pdN = busWrData[ST_PD];
                    n.toN = busWrData[ST_TO];
                end
                REG_PCLATCH: begin
                    n.pcLatch = busWrData;
                end
                REG_PC_LO: begin
                    n.pc[7:0] = busWrData;
                end
                REG_PC_HI: begin
                    n.pc[PC_W-1:8] = busWrData[PC_W-9:0];
                end
                REG_FILE_IDX: begin
                    n.fileIdx = busWrData[FILE_AW-1:0];
                end
                REG_FILE_DAT: begin
                    n.file[s.fileIdx] = busWrData;
                end
                default: begin
                end
            endcase
        end

        // register reads, data stand in the next cycle only
        if (busRd) begin
            case (busAddr)
                REG_ACC:      n.rdData = s.acc;
                REG_STATUS:   n.rdData = {3'h0, s.toN, s.pdN, s.z, s.dc, s.c};
                REG_PCLATCH:  n.rdData = s.pcLatch;
                REG_PC_LO:    n.rdData = s.pc[7:0];
                REG_PC_HI:    n.rdData = {3'h0, s.pc[PC_W-1:8]};
                REG_STK_LO:   n.rdData = stk.topAddr[7:0];
                REG_STK_HI:   n.rdData = {3'h0, stk.topAddr[PC_W-1:8]};
                REG_FILE_IDX: n.rdData = {1'b0, s.fileIdx};
                REG_FILE_DAT: n.rdData = s.file[s.fileIdx];
                default:      n.rdData = '0;
            endcase
        end

        // execution phases
        case (s.phase)
            PH_RUN: begin
                if (accept) begin
                    n.pc = s.pc + 13'h0001;
                    case (op)
                        OP_WDOG: begin
                            n.wdogClr = 1'b1;  // RULE1
                            n.toN     = 1'b1;  // RULE2
                            n.pdN     = 1'b1;  // RULE2
                        end
                        OP_CALL: begin
                            stk.push = 1'b1;  // RULE3
                            n.pc     = {s.pcLatch[4:3], instrWord[CALL_K_W-1:0]};  // RULE4
                            n.phase  = PH_CALL2;  // RULE5
                        end
                        OP_COMPLEMENT_FILE_OP, OP_DECREMENT_FILE_OP: begin
                            if (toFile) begin  // RULE6
                                n.file[fAddr] = result;  // RULE8
                            end else begin
                                n.acc = result;
                            end
                            n.z = (result == 8'h00);  // RULE12
                        end
                        OP_CLEAR_FILE_OP: begin
                            n.file[fAddr] = 8'h00;  // RULE7
                            n.z           = 1'b1;
                        end
                        OP_CLEAR_ACCUMULATOR_OP: begin
                            n.acc = 8'h00;  // RULE9
                            n.z   = 1'b1;
                        end
                        OP_DSKIP: begin  // RULE13
                            if (toFile) begin  // RULE10
                                n.file[fAddr] = result;
                            end else begin
                                n.acc = result;
                            end
                            if (result == 8'h00) begin
                                n.phase = PH_SKIP2;  // RULE11
                            end
                        end
                        default: begin
                        end
                    endcase
                end
            end
            PH_CALL2: begin
                // pipeline refill after the jump; pc already at the target
                n.phase = PH_RUN;  // RULE5
            end
            PH_SKIP2: begin
                // the word at pc is thrown away and a no-op runs in its slot
                n.pc    = s.pc + 13'h0001;  // RULE11
                n.phase = PH_RUN;
            end
            default: begin
                n.phase = PH_RUN;
            end
        endcase

        n.ready = (n.phase == PH_RUN);
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            s         <= '0;
            s.phase   <= PH_RUN;
            s.pc      <= PC_RST;
            s.acc     <= ACC_RST;
            s.pcLatch <= PCLATCH_RST;
            s.toN     <= TO_N_RST;
            s.pdN     <= PD_N_RST;
            s.ready   <= 1'b1;
        end else begin
            s <= n;
        end
    end

    return_stack u_stack (
        .sys_clk (sys_clk),
        .rst     (rst),
        .stk     (stk)
    );

    // every output is a flip-flop of the state
    assign busRdData      = s.rdData;
    assign instrReady     = s.ready;
    assign progCounter    = s.pc;
    assign watchdogClear  = s.wdogClr;
    assign timeoutFlagN   = s.toN;
    assign powerdownFlagN = s.pdN;
    assign zeroFlag       = s.z;
    assign accumulator    = s.acc;

    // checks
    logic statusWr;
    assign statusWr = busWr && (busAddr == REG_STATUS);

    wdog_pulse_a: assert property (@(posedge sys_clk) disable iff (rst)  // RULE1
        watchdogClear |-> $past(accept && op == OP_WDOG))
        else $error("watchdog clear pulse without its instruction");

    wdog_flags_a: assert property (@(posedge sys_clk) disable iff (rst)  // RULE2
        accept && op == OP_WDOG |=> watchdogClear && timeoutFlagN && powerdownFlagN)
        else $error("watchdog clear did not set timeout and power-down flags");

    call_push_a: assert property (@(posedge sys_clk) disable iff (rst)  // RULE3
        accept && op == OP_CALL |-> stk.push && stk.pushAddr == progCounter + 13'h0001)
        else $error("call did not push the return address");

    call_target_a: assert property (@(posedge sys_clk) disable iff (rst)  // RULE4
        accept && op == OP_CALL
        |=> progCounter == {$past(s.pcLatch[4:3]), $past(instrWord[CALL_K_W-1:0])})
        else $error("call target formed wrongly");

    call_cycles_a: assert property (@(posedge sys_clk) disable iff (rst)  // RULE5
        accept && op == OP_CALL |=> !instrReady ##1 instrReady)
        else $error("call did not take two cycles");

    complement_file_op_acc_a: assert property (@(posedge sys_clk) disable iff (rst)  // RULE6
        accept && op == OP_COMPLEMENT_FILE_OP && !toFile |=> accumulator == ~$past(fileRd))
        else $error("complement result not in accumulator");

    clear_file_op_zero_a: assert property (@(posedge sys_clk) disable iff (rst)  // RULE7
        accept && op == OP_CLEAR_FILE_OP |=> zeroFlag && s.file[$past(fAddr)] == 8'h00)
        else $error("clear-file did not zero register and set zero flag");

    decrement_file_op_file_a: assert property (@(posedge sys_clk) disable iff (rst)  // RULE8
        accept && op == OP_DECREMENT_FILE_OP && toFile
        |=> s.file[$past(fAddr)] == $past(fileRd) - 8'h01)
        else $error("decrement result not written back to file");

    clear_accumulator_op_zero_a: assert property (@(posedge sys_clk) disable iff (rst)  // RULE9
        accept && op == OP_CLEAR_ACCUMULATOR_OP |=> accumulator == 8'h00 && zeroFlag)
        else $error("clear-accumulator failed");

    dskip_acc_a: assert property (@(posedge sys_clk) disable iff (rst)  // RULE10
        accept && op == OP_DSKIP && !toFile |=> accumulator == $past(fileRd) - 8'h01)
        else $error("decrement-skip result not in accumulator");

    dskip_taken_a: assert property (@(posedge sys_clk) disable iff (rst)  // RULE11
        accept && op == OP_DSKIP && result == 8'h00
        |=> !instrReady && progCounter == $past(progCounter) + 13'h0001
        ##1 instrReady && progCounter == $past(progCounter, 2) + 13'h0002)
        else $error("zero result did not skip the next instruction");

    dskip_not_a: assert property (@(posedge sys_clk) disable iff (rst)  // RULE11
        accept && op == OP_DSKIP && result != 8'h00 |=> instrReady)
        else $error("nonzero result skipped");

    zero_from_a: assert property (@(posedge sys_clk) disable iff (rst)  // RULE12
        accept && (op == OP_COMPLEMENT_FILE_OP || op == OP_DECREMENT_FILE_OP) && !statusWr
        |=> zeroFlag == ($past(result) == 8'h00) && $stable(s.c) && $stable(s.dc))
        else $error("zero flag does not follow result");

    flags_keep_a: assert property (@(posedge sys_clk) disable iff (rst)  // RULE13
        accept && (op == OP_CALL || op == OP_DSKIP || op == OP_WDOG) && !statusWr
        |=> $stable(s.z) && $stable(s.c) && $stable(s.dc))
        else $error("flags changed by a flag-neutral instruction");

    // remaining write-back checks; the file ones look into the state, the file has no port of its own
    complement_file_op_file_a: assert property (@(posedge sys_clk) disable iff (rst)  // RULE6
        accept && op == OP_COMPLEMENT_FILE_OP && toFile |=> s.file[$past(fAddr)] == ~$past(fileRd))
        else $error("complement result not written back to file");

    decrement_file_op_acc_a: assert property (@(posedge sys_clk) disable iff (rst)  // RULE8
        accept && op == OP_DECREMENT_FILE_OP && !toFile |=> accumulator == $past(fileRd) - 8'h01)
        else $error("decrement result not in accumulator");

    dskip_file_a: assert property (@(posedge sys_clk) disable iff (rst)  // RULE10
        accept && op == OP_DSKIP && toFile
        |=> s.file[$past(fAddr)] == $past(fileRd) - 8'h01)
        else $error("decrement-skip result not written back to file");

    // stale read data would look like a second answer to software
    rd_idle_a: assert property (@(posedge sys_clk) disable iff (rst)
        !busRd |=> busRdData == 8'h00)
        else $error("read data outside the cycle after a read strobe");

    // scenarios worth seeing at least once
    call_seen_c: cover property (@(posedge sys_clk) disable iff (rst)
        accept && op == OP_CALL);
    skip_seen_c: cover property (@(posedge sys_clk) disable iff (rst)
        accept && op == OP_DSKIP && result == 8'h00);
    wdog_seen_c: cover property (@(posedge sys_clk) disable iff (rst)
        accept && op == OP_WDOG);
    complement_file_op_seen_c: cover property (@(posedge sys_clk) disable iff (rst)
        accept && op == OP_COMPLEMENT_FILE_OP);
    clear_seen_c: cover property (@(posedge sys_clk) disable iff (rst)
        accept && (op == OP_CLEAR_FILE_OP || op == OP_CLEAR_ACCUMULATOR_OP));
endmodule

// *** cpu_instr_exec_subset_tb.sv ***
`timescale 1ns/1ps
module cpu_instr_exec_subset_tb;
    import exec_pkg::*;

    typedef struct {
        logic [INSTR_W-1:0] word;
        logic [DATA_W-1:0]  fileIn;
        logic [DATA_W-1:0]  expAcc;
        logic [DATA_W-1:0]  expFile;
        logic               expZ;
        logic               expFlagN;
    } row_t;

    logic                 sys_clk;
    logic                 rst;
    logic [BUS_AW-1:0]    busAddr;
    logic [DATA_W-1:0]    busWrData;
    logic                 busWr;
    logic                 busRd;
    logic [DATA_W-1:0]    busRdData;
    logic [INSTR_W-1:0]   instrWord;
    logic                 instrValid;
    logic                 instrReady;
    logic [PC_W-1:0]      progCounter;
    logic                 watchdogClear;
    logic                 timeoutFlagN;
    logic                 powerdownFlagN;
    logic                 zeroFlag;
    logic [DATA_W-1:0]    accumulator;
    logic [DATA_W-1:0]    rd;
    logic [PC_W-1:0]      pcBefore;
    int                   miscompares;
    int                   comparisons;
    row_t                 rows [9];

    cpu_instr_exec i_dut (
        .sys_clk(sys_clk), .rst(rst), .busAddr(busAddr), .busWrData(busWrData),
        .busWr(busWr), .busRd(busRd), .busRdData(busRdData), .instrWord(instrWord),
        .instrValid(instrValid), .instrReady(instrReady), .progCounter(progCounter),
        .watchdogClear(watchdogClear), .timeoutFlagN(timeoutFlagN),
        .powerdownFlagN(powerdownFlagN), .zeroFlag(zeroFlag), .accumulator(accumulator)
    );

    // free-running 50 MHz clock
    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end

    task automatic close_out();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // one compare task per result width
    task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chk13(input string what, input logic [12:0] exp, input logic [12:0] got);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chk1(input string what, input logic exp, input logic got);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected %s expected %b seen %b", what, exp, got);
        end
    endtask

    // register port: one-cycle strobes, read data only in the following cycle
    task automatic regWr(input logic [BUS_AW-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge sys_clk);
        busAddr <= a;
        busWrData <= d;
        busWr <= 1'b1;
        @(posedge sys_clk);
        busWr <= 1'b0;
        #1;
    endtask

    task automatic regRd(input logic [BUS_AW-1:0] a, output logic [DATA_W-1:0] d);
        @(posedge sys_clk);
        busAddr <= a;
        busRd <= 1'b1;
        @(posedge sys_clk);
        busRd <= 1'b0;
        #1;
        d = busRdData;
    endtask

    task automatic setFile(input logic [DATA_W-1:0] f, input logic [DATA_W-1:0] v);
        regWr(REG_FILE_IDX, f);
        regWr(REG_FILE_DAT, v);
    endtask

    // word held valid until taken; returns just after the taking edge
    task automatic exec(input logic [INSTR_W-1:0] w);
        int n;
        @(posedge sys_clk);
        instrWord <= w;
        instrValid <= 1'b1;
        #1;
        n = 0;
        while (instrReady !== 1'b1 && n < 10) begin
            @(posedge sys_clk);
            #1;
            n++;
        end
        if (instrReady !== 1'b1) begin
            miscompares++;
            $display("unexpected instrReady expected 1 seen %b", instrReady);
            close_out();
        end
        @(posedge sys_clk);
        instrValid <= 1'b0;
        #1;
    endtask

    task automatic checkReset();
        @(posedge sys_clk);
        #1;
        chk13("progCounter", PC_RST, progCounter);
        chk8("accumulator", ACC_RST, accumulator);
        chk1("zeroFlag", 1'b0, zeroFlag);
        chk1("instrReady", 1'b1, instrReady);
        chk1("watchdogClear", 1'b0, watchdogClear);
        chk1("timeoutFlagN", TO_N_RST, timeoutFlagN);
        chk1("powerdownFlagN", PD_N_RST, powerdownFlagN);
        chk8("busRdData", 8'h00, busRdData);
    endtask

    // call with latch bits 4..3 on top of k; return address pushed
    task automatic callCheck(input logic [DATA_W-1:0] latch, input logic [10:0] k);
        logic [PC_W-1:0] ret;
        regWr(REG_PCLATCH, latch);
        regWr(REG_STATUS, 8'h04);
        ret = progCounter + 13'h0001;
        exec({3'b100, k});
        chk13("call target", {latch[4:3], k}, progCounter);
        chk1("instrReady", 1'b0, instrReady);
        @(posedge sys_clk);
        #1;
        chk1("instrReady", 1'b1, instrReady);
        chk1("zeroFlag", 1'b1, zeroFlag);
        regRd(REG_STK_LO, rd);
        chk8("stack top low", ret[7:0], rd);
        regRd(REG_STK_HI, rd);
        chk8("stack top high", {3'b000, ret[12:8]}, rd);
        $display("test call %h done", k);
    endtask

    initial begin
        rst = 1'b1;
        busAddr = 4'h0;
        busWrData = 8'h00;
        busWr = 1'b0;
        busRd = 1'b0;
        instrWord = 14'h0000;
        instrValid = 1'b0;
        miscompares = 0;
        comparisons = 0;
        // word, file in, acc out, file out, zero, both status flags
        rows[0] = '{14'h0920, 8'h0F, 8'hF0, 8'h0F, 1'b0, 1'b0};
        rows[1] = '{14'h09A0, 8'hFF, 8'h5A, 8'h00, 1'b1, 1'b0};
        rows[2] = '{14'h0320, 8'h01, 8'h00, 8'h01, 1'b1, 1'b0};
        rows[3] = '{14'h03A0, 8'h00, 8'h5A, 8'hFF, 1'b0, 1'b0};
        rows[4] = '{14'h01A0, 8'h77, 8'h5A, 8'h00, 1'b1, 1'b0};
        rows[5] = '{14'h0100, 8'h33, 8'h00, 8'h33, 1'b1, 1'b0};
        rows[6] = '{14'h0BA0, 8'h05, 8'h5A, 8'h04, 1'b1, 1'b0};
        rows[7] = '{14'h0B20, 8'h03, 8'h02, 8'h03, 1'b1, 1'b0};
        rows[8] = '{14'h0064, 8'h44, 8'h5A, 8'h44, 1'b1, 1'b1};
        repeat (5) @(posedge sys_clk);
        rst <= 1'b0;
        checkReset();
        $display("test reset done");
        // status preset with carries and zero set, both low-active flags cleared
        foreach (rows[i]) begin
            setFile(8'h20, rows[i].fileIn);
            regWr(REG_ACC, 8'h5A);
            regWr(REG_STATUS, 8'h07);
            pcBefore = progCounter;
            exec(rows[i].word);
            chk1("watchdogClear", rows[i].word == WDOG_OPC, watchdogClear);
            chk13("progCounter", pcBefore + 13'h0001, progCounter);
            chk1("instrReady", 1'b1, instrReady);
            chk8("accumulator", rows[i].expAcc, accumulator);
            chk1("zeroFlag", rows[i].expZ, zeroFlag);
            chk1("timeoutFlagN", rows[i].expFlagN, timeoutFlagN);
            chk1("powerdownFlagN", rows[i].expFlagN, powerdownFlagN);
            @(posedge sys_clk);
            #1;
            chk1("watchdogClear end", 1'b0, watchdogClear);
            regRd(REG_FILE_DAT, rd);
            chk8("file register", rows[i].expFile, rd);
            regRd(REG_STATUS, rd);
            chk8("status", {3'b000, {2{rows[i].expFlagN}}, rows[i].expZ, 2'b11}, rd);
            $display("test row %0d done", i);
        end
        // second call pushes the first target plus one; bit 2 of latch must not leak
        callCheck(8'h0C, 11'h5A5);
        callCheck(8'h10, 11'h7FF);
        // zero result into the accumulator: skip taken, zero flag untouched
        regWr(REG_STATUS, 8'h00);
        setFile(8'h21, 8'h01);
        pcBefore = progCounter;
        exec(14'h0B21);
        chk13("progCounter", pcBefore + 13'h0001, progCounter);
        chk1("instrReady", 1'b0, instrReady);
        chk8("accumulator", 8'h00, accumulator);
        @(posedge sys_clk);
        #1;
        chk13("progCounter", pcBefore + 13'h0002, progCounter);
        chk1("instrReady", 1'b1, instrReady);
        chk1("zeroFlag", 1'b0, zeroFlag);
        regRd(REG_FILE_DAT, rd);
        chk8("file register", 8'h01, rd);
        $display("test skip done");
        // unmapped index reads zero; read data stands one cycle only
        // pc and latch over the port; an unknown word runs as a plain step
        regWr(REG_PC_LO, 8'h34);
        regWr(REG_PC_HI, 8'hF2);
        regRd(REG_PC_HI, rd);
        chk8("pc high", 8'h12, rd);
        regRd(REG_PC_LO, rd);
        chk8("pc low", 8'h34, rd);
        regRd(REG_PCLATCH, rd);
        chk8("pc latch", 8'h10, rd);
        regRd(REG_FILE_IDX, rd);
        chk8("file index", 8'h21, rd);
        exec(14'h3FFF);
        chk13("progCounter", 13'h1235, progCounter);
        regWr(4'hF, 8'hA5);
        regRd(4'hF, rd);
        chk8("unmapped read", 8'h00, rd);
        regRd(REG_ACC, rd);
        chk8("accumulator read", 8'h00, rd);
        @(posedge sys_clk);
        #1;
        chk8("busRdData idle", 8'h00, busRdData);
        $display("test bus done");
        // second reset in mid-run
        @(posedge sys_clk);
        rst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        checkReset();
        regRd(REG_FILE_DAT, rd);
        chk8("file after reset", 8'h00, rd);
        $display("test rerun reset done");
        close_out();
    end
endmodule
